// File: common/tcc_pkg.sv
// Shared constants and types of the timer control block
package tcc_pkg;
   localparam int TCC_DATA_W = 32;
   localparam int TCC_ADDR_W = 16;
   localparam int TCC_CNT_W = 16;
   localparam int TCC_IRQ_W = 2;
   localparam int TCC_SYNC_W = 3;
   localparam logic [11:0] TCC_IDX_CTRL = 12'hFCD;
   localparam logic [11:0] TCC_IDX_CNT_LO = 12'hFD0;
   localparam logic [11:0] TCC_IDX_CNT_HI = 12'hFD1;
   localparam logic [11:0] TCC_IDX_OSC = 12'hFD2;
   localparam logic [11:0] TCC_IDX_STAT = 12'hFD3;
   localparam logic [11:0] TCC_IDX_IRQ_ST = 12'hFD4;
   localparam logic [11:0] TCC_IDX_IRQ_MSK = 12'hFD5;
   localparam int TCC_CS_LSB = 6;
   localparam int TCC_PS_LSB = 4;
   localparam int TCC_XEN_BIT = 3;
   localparam int TCC_SYNCB_BIT = 2;
   localparam int TCC_WIDE_BIT = 1;
   localparam int TCC_RUN_BIT = 0;
   localparam int TCC_SCS_LSB = 0;
   localparam int TCC_IDLE_BIT = 7;
   localparam int TCC_ST_RUNNING_BIT = 0;
   localparam int TCC_ST_SECONDARY_RUN_MODE_BIT = 1;
   localparam int TCC_ST_SECONDARY_IDLE_MODE_BIT = 2;
   localparam int TCC_ST_FAILED_BIT = 3;
   localparam int TCC_IRQ_OVF_BIT = 0;
   localparam int TCC_IRQ_FAIL_BIT = 1;
   localparam int TCC_SYNC_PIN = 0;
   localparam int TCC_SYNC_OSC = 1;
   localparam int TCC_SYNC_FAIL = 2;
   localparam logic [7:0] TCC_CTRL_RST = 8'h00;
   localparam logic [1:0] TCC_SCS_RST = 2'h0;
   localparam logic TCC_IDLE_RST = 1'b0;
   localparam logic [1:0] TCC_MASK_RST = 2'h0;
   localparam logic [1:0] TCC_SCS_TIMER_OSC = 2'h1;
   localparam int TCC_INSTR_DIV = 4;
   localparam logic [1:0] TCC_PHASE_LAST = 2'(TCC_INSTR_DIV - 1);
   localparam logic [15:0] TCC_CNT_MAX = 16'hFFFF;
   typedef enum logic [1:0] {SRC_INSTR = 2'h0, SRC_SYS = 2'h1, SRC_EXT = 2'h2} tcc_src_e;
   typedef enum logic [1:0] {PS_DIV1 = 2'h0, PS_DIV2 = 2'h1, PS_DIV4 = 2'h2,
      PS_DIV8 = 2'h3} tcc_ps_e;
   typedef enum logic [2:0] {ST_PRI_RUN = 3'h1, ST_SECONDARY_RUN_MODE = 3'h2,
      ST_SECONDARY_IDLE_MODE = 3'h4} tcc_clk_state_e;
endpackage

// File: common/tcc_tick_if.sv
// Count tick path between the timer control and its prescaler
`timescale 1ns/1ps
interface tcc_tick_if;
   logic src_tick;
   logic [1:0] ps_sel;
   logic clr;
   logic out_tick;
   modport src (output src_tick, output ps_sel, output clr, input out_tick);
   modport pre (input src_tick, input ps_sel, input clr, output out_tick);
endinterface

// File: hdl/tcc_prescaler.sv
// Input prescaler dividing the selected count tick by 1, 2, 4 or 8
`timescale 1ns/1ps
module tcc_prescaler (
   input wire logic core_clk_i,
   input wire logic rst_i,
   tcc_tick_if.pre tk
);
   import tcc_pkg::*;

   logic [2:0] div_cnt;
   logic [2:0] limit;

   always_comb
   begin
      case (tk.ps_sel)
         PS_DIV1: limit = 3'h0;
         PS_DIV2: limit = 3'h1;
         PS_DIV4: limit = 3'h3;
         PS_DIV8: limit = 3'h7;
         default: limit = 3'h0;
      endcase
   end

   // A count left past the limit by a ratio change ends its period at once
   assign tk.out_tick = tk.src_tick && (div_cnt >= limit); // R2

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i || tk.clr)
      begin
         div_cnt <= 3'h0;
      end
      else if (tk.src_tick)
      begin
         div_cnt <= (div_cnt >= limit) ? 3'h0 : div_cnt + 3'h1; // R2
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_ps_bypass_pass: assert property ((tk.ps_sel == PS_DIV1) |-> (tk.out_tick == tk.src_tick)) // R2
      else $error("undivided prescale does not pass every tick");
   chk_ps_div8_gap: assert property ((tk.out_tick && tk.ps_sel == PS_DIV8) |=> // R2
      (!tk.out_tick || tk.ps_sel != PS_DIV8)[*7])
      else $error("divide by eight emitted ticks too close together");
endmodule // tcc_prescaler

// File: hdl/tcc_timer_ctrl.sv
// Timer control: clock source, prescale, 16-bit count, secondary clock modes, APB registers
// Overview of operation
// R1: Source select 10 external or oscillator, 01 system clock, 00 instruction clock.
// R2: Prescale field divides the selected source by 8, 4, 2 or 1.
// R3: With source 10, crystal enable picks oscillator output, otherwise the count pin.
// R4: Crystal driver powered by OR of both timers' crystal enables, ignoring run bits.
// R5: External source: bypass set counts unsynchronised, clear synchronises; ignored when internal.
// R6: Wide mode moves the 16-bit count as one operation; else two bytes.
// R7: Wide mode: low read latches high byte; high write waits for low write.
// R8: Software should avoid system-clock source when capture or compare uses the timer.
// R9: System clock select 01 enters secondary run, clocked from timer oscillator.
// R10: Sleep in secondary run with idle-on-sleep clear enters secondary idle.
// R11: Oscillator-running flag is set exactly while timer oscillator supplies system clock.
// R12: Monitored oscillator failure moves clock elsewhere and the flag shows it.
// R13: Run bit enables counting; clearing it stops and keeps the count.
// R14: Count rolls from FFFF to 0000 latching the overflow flag.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module tcc_timer_ctrl (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [tcc_pkg::TCC_ADDR_W-1:0] paddr_i,
   input wire logic [tcc_pkg::TCC_DATA_W-1:0] pwdata_i,
   output logic [tcc_pkg::TCC_DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic external_count_input_i,
   input wire logic low_power_oscillator_i,
   input wire logic companion_crystal_enable_i,
   input wire logic sleep_req_i,
   input wire logic wake_i,
   input wire logic fscm_enable_i,
   input wire logic osc_fail_i,
   output logic crystal_driver_en_o,
   output logic secondary_run_mode_o,
   output logic secondary_idle_mode_o,
   output logic secondary_osc_running_o,
   output logic [tcc_pkg::TCC_CNT_W-1:0] count_o,
   output logic overflow_pulse_o,
   output logic irq_o
);
   import tcc_pkg::*;

   tcc_tick_if tk ();

   logic [7:0] ctrl;
   logic [1:0] system_clock_select;
   logic idle_on_sleep;
   logic [TCC_IRQ_W-1:0] irq_st;
   logic [TCC_IRQ_W-1:0] irq_mask;
   logic [TCC_SYNC_W-1:0] sync1;
   logic [TCC_SYNC_W-1:0] sync2;
   logic [1:0] phase;
   logic ext_prev;
   logic ext_pend;
   logic ext_lvl;
   logic ext_rise;
   logic ext_tick;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] snap_count;
   logic [7:0] hold_hi;
   logic [7:0] wbuf;
   logic cnt_ovf;
   logic fail_latched;
   logic fail_event;
   tcc_clk_state_e state;
   tcc_clk_state_e next_state;
   logic [1:0] cs;
   logic xen;
   logic sync_bypass;
   logic wide_access_mode;
   logic timer_run;
   logic setup;
   logic acc;
   logic wr_en;
   logic rd_en;
   logic aligned;
   logic mapped;
   logic [11:0] idx;
   logic sel_ctrl;
   logic sel_lo;
   logic sel_hi;
   logic sel_osc;
   logic sel_irq;
   logic sel_msk;
   logic cnt_wr;
   logic [TCC_DATA_W-1:0] rd_mux;

   assign cs = ctrl[TCC_CS_LSB +: 2];
   assign xen = ctrl[TCC_XEN_BIT];
   assign sync_bypass = ctrl[TCC_SYNCB_BIT];
   assign wide_access_mode = ctrl[TCC_WIDE_BIT];
   assign timer_run = ctrl[TCC_RUN_BIT];

   // APB slave, no wait states
   assign setup = psel_i && !penable_i;
   assign acc = psel_i && penable_i;
   assign wr_en = acc && pwrite_i;
   assign rd_en = acc && !pwrite_i;
   assign idx = paddr_i[13:2];
   assign aligned = (paddr_i[15:14] == 2'h0) && (paddr_i[1:0] == 2'h0);
   assign sel_ctrl = aligned && (idx == TCC_IDX_CTRL);
   assign sel_lo = aligned && (idx == TCC_IDX_CNT_LO);
   assign sel_hi = aligned && (idx == TCC_IDX_CNT_HI);
   assign sel_osc = aligned && (idx == TCC_IDX_OSC);
   assign sel_irq = aligned && (idx == TCC_IDX_IRQ_ST);
   assign sel_msk = aligned && (idx == TCC_IDX_IRQ_MSK);
   assign mapped = sel_ctrl || sel_lo || sel_hi || sel_osc || sel_irq || sel_msk
      || (aligned && (idx == TCC_IDX_STAT));
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !mapped;
   assign cnt_wr = wr_en && (sel_lo || (sel_hi && !wide_access_mode));

   always_comb
   begin
      rd_mux = '0;
      if (sel_ctrl)
      begin
         rd_mux[7:0] = ctrl;
      end
      else if (sel_lo)
      begin
         rd_mux[7:0] = count[7:0];
      end
      else if (sel_hi)
      begin
         rd_mux[7:0] = wide_access_mode ? hold_hi : count[15:8]; // R6
      end
      else if (sel_osc)
      begin
         rd_mux[TCC_IDLE_BIT] = idle_on_sleep;
         rd_mux[TCC_SCS_LSB +: 2] = system_clock_select;
      end
      else if (aligned && (idx == TCC_IDX_STAT))
      begin
         rd_mux[TCC_ST_RUNNING_BIT] = secondary_osc_running_o;
         rd_mux[TCC_ST_SECONDARY_RUN_MODE_BIT] = secondary_run_mode_o;
         rd_mux[TCC_ST_SECONDARY_IDLE_MODE_BIT] = secondary_idle_mode_o;
         rd_mux[TCC_ST_FAILED_BIT] = fail_latched;
      end
      else if (sel_irq)
      begin
         rd_mux[TCC_IRQ_W-1:0] = irq_st;
      end
      else if (sel_msk)
      begin
         rd_mux[TCC_IRQ_W-1:0] = irq_mask;
      end
   end

   // Read data and count snapshot are taken in the setup cycle
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         prdata_o <= '0;
         snap_count <= 16'h0000;
      end
      else if (setup)
      begin
         prdata_o <= rd_mux;
         snap_count <= count;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         ctrl <= TCC_CTRL_RST;
         system_clock_select <= TCC_SCS_RST;
         idle_on_sleep <= TCC_IDLE_RST;
         irq_mask <= TCC_MASK_RST;
      end
      else if (wr_en)
      begin
         if (sel_ctrl)
         begin
            ctrl <= pwdata_i[7:0];
         end
         if (sel_osc)
         begin
            system_clock_select <= pwdata_i[TCC_SCS_LSB +: 2];
            idle_on_sleep <= pwdata_i[TCC_IDLE_BIT];
         end
         if (sel_msk)
         begin
            irq_mask <= pwdata_i[TCC_IRQ_W-1:0];
         end
      end
   end

   // Wide mode byte buffers keep the two halves of a 16-bit access coherent
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         hold_hi <= 8'h00;
         wbuf <= 8'h00;
      end
      else
      begin
         if (rd_en && sel_lo && wide_access_mode)
         begin
            hold_hi <= snap_count[15:8]; // R7
         end
         if (wr_en && sel_hi && wide_access_mode)
         begin
            wbuf <= pwdata_i[7:0]; // R7
         end
      end
   end

   // Async pins and the fail indication pass two flip-flops first
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {osc_fail_i, low_power_oscillator_i, external_count_input_i};
         sync2 <= sync1;
      end
   end

   // Bypass still sees the two-stage synchroniser; sync mode further aligns to instruction phase
   assign ext_lvl = xen ? sync2[TCC_SYNC_OSC] : sync2[TCC_SYNC_PIN]; // R3
   assign ext_rise = ext_lvl && !ext_prev;
   assign ext_tick = sync_bypass ? ext_rise : ((ext_rise || ext_pend) && phase == 2'h0); // R5

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         phase <= 2'h0;
         ext_prev <= 1'b0;
         ext_pend <= 1'b0;
      end
      else
      begin
         phase <= (phase == TCC_PHASE_LAST) ? 2'h0 : phase + 2'h1;
         ext_prev <= ext_lvl;
         if (phase == 2'h0)
         begin
            ext_pend <= 1'b0;
         end
         else if (ext_rise)
         begin
            ext_pend <= 1'b1;
         end
      end
   end

   // Unused code 11 counts like the instruction clock
   always_comb
   begin
      case (cs)
         SRC_SYS: tk.src_tick = 1'b1; // R1
         SRC_EXT: tk.src_tick = ext_tick; // R1
         default: tk.src_tick = (phase == 2'h0); // R1
      endcase
   end
   assign tk.ps_sel = ctrl[TCC_PS_LSB +: 2];
   assign tk.clr = cnt_wr;

   tcc_prescaler u_prescaler (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .tk(tk)
   );

   // A register write wins over a coinciding tick
   always_comb
   begin
      next_count = count;
      cnt_ovf = 1'b0;
      if (tk.out_tick && timer_run)
      begin
         next_count = count + 16'h0001; // R13 R14
         cnt_ovf = (count == TCC_CNT_MAX); // R14
      end
      if (wr_en && sel_lo)
      begin
         next_count = wide_access_mode ? {wbuf, pwdata_i[7:0]} : {count[15:8], pwdata_i[7:0]}; // R6
         cnt_ovf = 1'b0;
      end
      else if (wr_en && sel_hi && !wide_access_mode)
      begin
         next_count = {pwdata_i[7:0], count[7:0]}; // R6
         cnt_ovf = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         count <= 16'h0000;
         overflow_pulse_o <= 1'b0;
      end
      else
      begin
         count <= next_count;
         overflow_pulse_o <= cnt_ovf;
      end
   end
   assign count_o = count;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         crystal_driver_en_o <= 1'b0;
      end
      else
      begin
         crystal_driver_en_o <= xen || companion_crystal_enable_i; // R4
      end
   end

   // Secondary clock modes
   assign fail_event = fscm_enable_i && sync2[TCC_SYNC_FAIL] && (state != ST_PRI_RUN);

   always_comb
   begin
      next_state = state;
      case (state)
         ST_PRI_RUN:
         begin
            if (system_clock_select == TCC_SCS_TIMER_OSC && !fail_latched)
            begin
               next_state = ST_SECONDARY_RUN_MODE; // R9
            end
         end
         ST_SECONDARY_RUN_MODE:
         begin
            if (fail_event || system_clock_select != TCC_SCS_TIMER_OSC)
            begin
               next_state = ST_PRI_RUN; // R12
            end
            else if (sleep_req_i && !idle_on_sleep)
            begin
               next_state = ST_SECONDARY_IDLE_MODE; // R10
            end
         end
         ST_SECONDARY_IDLE_MODE:
         begin
            if (fail_event)
            begin
               next_state = ST_PRI_RUN; // R12
            end
            else if (wake_i)
            begin
               next_state = ST_SECONDARY_RUN_MODE;
            end
         end
         default: next_state = ST_PRI_RUN;
      endcase
   end

   // Once failed, the oscillator is not reselected until software rewrites the select
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state <= ST_PRI_RUN;
         fail_latched <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (fail_event)
         begin
            fail_latched <= 1'b1; // R12
         end
         else if (wr_en && sel_osc)
         begin
            fail_latched <= 1'b0;
         end
      end
   end
   assign secondary_run_mode_o = (state == ST_SECONDARY_RUN_MODE);
   assign secondary_idle_mode_o = (state == ST_SECONDARY_IDLE_MODE);
   assign secondary_osc_running_o = (state != ST_PRI_RUN); // R11

   // Read clears only the bits reported; a new event wins
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         irq_st <= '0;
         irq_o <= 1'b0;
      end
      else
      begin
         irq_st <= (irq_st & ~((rd_en && sel_irq) ? prdata_o[TCC_IRQ_W-1:0] : 2'h0))
            | {fail_event, cnt_ovf}; // R14
         irq_o <= |(irq_st & irq_mask);
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_lo_read_wide;
      rd_en && sel_lo && wide_access_mode;
   endsequence
   sequence s_scs_to_osc;
      wr_en && sel_osc && pwdata_i[1:0] == TCC_SCS_TIMER_OSC && state == ST_PRI_RUN;
   endsequence

   chk_sys_src_tick: assert property ((cs == SRC_SYS) |-> tk.src_tick) // R1
      else $error("system clock source missed a tick");
   chk_instr_div_four: assert property ((cs == SRC_INSTR && tk.src_tick) |=> // R1
      (!tk.src_tick || cs != SRC_INSTR)[*3])
      else $error("instruction clock ticked faster than one in four");
   chk_osc_rise_ticks: assert property ((cs == SRC_EXT && xen && sync_bypass && // R3
      $rose(sync2[TCC_SYNC_OSC]) && $stable(ctrl)) |-> tk.src_tick)
      else $error("oscillator edge not counted");
   chk_pin_quiet_idle: assert property ((cs == SRC_EXT && !xen && // R3
      $stable(sync2[TCC_SYNC_PIN]) && $stable(ctrl)) |-> !ext_rise)
      else $error("count taken without a pin edge");
   chk_drv_or_enable: assert property (1'b1 |=> // R4
      crystal_driver_en_o == ($past(xen) || $past(companion_crystal_enable_i)))
      else $error("crystal driver enable not the OR of both enables");
   chk_sync_on_phase: assert property ((cs == SRC_EXT && !sync_bypass && tk.src_tick) // R5
      |-> phase == 2'h0)
      else $error("synchronised external tick off instruction phase");
   chk_wide_hold_hi: assert property (s_lo_read_wide |=> hold_hi == $past(snap_count[15:8])) // R7
      else $error("low byte read did not latch the high byte");
   chk_wide_write_pair: assert property ((wr_en && sel_lo && wide_access_mode) |=> // R6
      count == {$past(wbuf), $past(pwdata_i[7:0])})
      else $error("wide write did not load both bytes together");
   chk_byte_write_lo: assert property ((wr_en && sel_lo && !wide_access_mode) |=> // R6
      count[15:8] == $past(count[15:8]))
      else $error("byte write disturbed the high byte");
   chk_secondary_run_mode_entry: assert property (s_scs_to_osc |=> ##1 state == ST_SECONDARY_RUN_MODE) // R9
      else $error("select 01 did not enter secondary run");
   chk_sleep_to_idle: assert property ((state == ST_SECONDARY_RUN_MODE && system_clock_select == TCC_SCS_TIMER_OSC && // R10
      sleep_req_i && !idle_on_sleep && !fail_event) |=> state == ST_SECONDARY_IDLE_MODE)
      else $error("sleep did not enter secondary idle");
   chk_running_cause: assert property ($rose(secondary_osc_running_o) |-> // R11
      $past(system_clock_select) == TCC_SCS_TIMER_OSC && !$past(fail_latched))
      else $error("running flag rose without oscillator selected");
   chk_fail_switch: assert property (fail_event |=> // R12
      !secondary_osc_running_o && fail_latched && irq_st[TCC_IRQ_FAIL_BIT])
      else $error("oscillator failure not reported");
   chk_stop_holds: assert property ((!timer_run && !cnt_wr) |=> $stable(count)) // R13
      else $error("count moved while stopped");
   chk_rollover_flag: assert property ((count == TCC_CNT_MAX && tk.out_tick && timer_run // R14
      && !cnt_wr) |=> count == 16'h0000 && irq_st[TCC_IRQ_OVF_BIT] && overflow_pulse_o)
      else $error("rollover did not latch the overflow flag");
endmodule // tcc_timer_ctrl

// File: dv/tcc_osc_model.sv
// Far-side model: crystal oscillator output and external count pin
`timescale 1ns/1ps
module tcc_osc_model (
   input wire logic core_clk_i,
   input wire logic osc_run_i,
   input wire logic pin_run_i,
   output logic osc_o,
   output logic pin_o
);
   logic [3:0] phase = 4'h0;
   logic osc_q = 1'b0;
   logic pin_q = 1'b0;
   assign osc_o = osc_q;
   assign pin_o = pin_q;
   // Fixed periods of 8 and 16 clocks keep edge counts exact over 128 cycles
   always @(posedge core_clk_i)
   begin
      phase <= phase + 4'h1;
      if (osc_run_i && phase[1:0] == 2'h3)
         osc_q <= ~osc_q;
      if (pin_run_i && phase[2:0] == 3'h5)
         pin_q <= ~pin_q;
   end
endmodule // tcc_osc_model

// File: dv/tcc_timer_ctrl_tb_top.sv
// Self-checking bench of the timer control block
`timescale 1ns/1ps
module tcc_timer_ctrl_tb_top;
   import tcc_pkg::*;
   logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [15:0] paddr_i, count_o, c0, d;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic external_count_input_i, low_power_oscillator_i, companion_crystal_enable_i;
   logic sleep_req_i, wake_i, fscm_enable_i, osc_fail_i, crystal_driver_en_o;
   logic secondary_run_mode_o, secondary_idle_mode_o, secondary_osc_running_o;
   logic overflow_pulse_o, irq_o, er, osc_run, pin_run;
   logic [7:0] ctrl;
   int err_count, cmp_count, cyc, n;

   tcc_timer_ctrl uut (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .external_count_input_i,
      .low_power_oscillator_i, .companion_crystal_enable_i, .sleep_req_i, .wake_i,
      .fscm_enable_i, .osc_fail_i, .crystal_driver_en_o, .secondary_run_mode_o,
      .secondary_idle_mode_o, .secondary_osc_running_o, .count_o, .overflow_pulse_o, .irq_o);
   tcc_osc_model far (.core_clk_i, .osc_run_i(osc_run), .pin_run_i(pin_run),
      .osc_o(low_power_oscillator_i), .pin_o(external_count_input_i));

   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Generous ceiling: the full sequence needs about 2000 cycles
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         summarize();
      end
   end

   task apb(input logic wr, input logic [15:0] a, input logic [7:0] wd);
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= {24'h000000, wd};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      @(posedge core_clk_i);
      while (pready_o !== 1'b1)
         @(posedge core_clk_i);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task wr(input logic [11:0] idx, input logic [7:0] wd);
      apb(1'b1, {2'b00, idx, 2'b00}, wd);
   endtask

   task rdc(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
      chk(rd, exp);
   endtask

   // Counts taken at edges only, so windows that span whole tick periods are exact
   task rate(input logic [7:0] cv);
      wr(TCC_IDX_CTRL, cv);
      repeat (8) @(posedge core_clk_i);
      c0 = count_o;
      repeat (128) @(posedge core_clk_i);
      d = count_o - c0;
   endtask

   initial
   begin
      rst_i = 1'b1;
      {psel_i, penable_i, pwrite_i, sleep_req_i, wake_i, fscm_enable_i, osc_fail_i} = 7'h00;
      {companion_crystal_enable_i, osc_run, pin_run} = 3'h0;
      paddr_i = 16'h0000;
      pwdata_i = 32'h00000000;
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rdc(TCC_IDX_CTRL, 32'h00000000);
      rdc(TCC_IDX_IRQ_MSK, 32'h00000000);
      rdc(TCC_IDX_STAT, 32'h00000000);
      chk(count_o, 32'h00000000);
      wr(TCC_IDX_CTRL, 8'hFE);
      rdc(TCC_IDX_CTRL, 32'h000000FE);
      apb(1'b0, 16'h3F36, 8'h00);
      chk(er, 1'b1);
      chk(rd, 32'h00000000);
      for (n = 0; n < 4; n++)
      begin
         wr(TCC_IDX_CTRL, n[0] ? 8'h08 : 8'h00);
         companion_crystal_enable_i <= n[1];
         repeat (2) @(posedge core_clk_i);
         chk(crystal_driver_en_o, n[0] | n[1]);
      end
      // Capture and compare are not in use, so the system clock source is allowed
      for (n = 0; n < 8; n++)
      begin
         ctrl = {1'b0, n[2], n[1:0], 1'b0, n[0], 1'b0, 1'b1};
         rate(ctrl);
         chk(d, 16'(128 >> (n[1:0] + (n[2] ? 0 : 2))));
      end
      wr(TCC_IDX_CTRL, 8'h40);
      c0 = count_o;
      repeat (20) @(posedge core_clk_i);
      chk(count_o, c0);
      osc_run <= 1'b1;
      rate(8'h89);
      chk(d, 16);
      rate(8'h8D);
      chk(d, 16);
      rate(8'h81);
      chk(d, 0);
      osc_run <= 1'b0;
      pin_run <= 1'b1;
      rate(8'h85);
      chk(d, 8);
      rate(8'h81);
      chk(d, 8);
      pin_run <= 1'b0;
      wr(TCC_IDX_CTRL, 8'h02);
      c0 = count_o;
      wr(TCC_IDX_CNT_HI, 8'h12);
      chk(count_o, c0);
      wr(TCC_IDX_CNT_LO, 8'h34);
      @(posedge core_clk_i);
      chk(count_o, 16'h1234);
      rdc(TCC_IDX_CNT_LO, 32'h34);
      wr(TCC_IDX_CNT_HI, 8'h56);
      rdc(TCC_IDX_CNT_HI, 32'h12);
      wr(TCC_IDX_CTRL, 8'h00);
      wr(TCC_IDX_CNT_HI, 8'hFF);
      @(posedge core_clk_i);
      chk(count_o, 16'hFF34);
      wr(TCC_IDX_CNT_LO, 8'hF0);
      wr(TCC_IDX_CTRL, 8'h41);
      n = 0;
      repeat (40)
      begin
         @(posedge core_clk_i);
         if (overflow_pulse_o === 1'b1)
            n++;
      end
      wr(TCC_IDX_CTRL, 8'h40);
      chk(n, 1);
      chk(irq_o, 1'b0);
      wr(TCC_IDX_IRQ_MSK, 8'h01);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 1'b1);
      rdc(TCC_IDX_IRQ_ST, 32'h1);
      rdc(TCC_IDX_IRQ_ST, 32'h0);
      chk(irq_o, 1'b0);
      wr(TCC_IDX_OSC, 8'h01);
      repeat (3) @(posedge core_clk_i);
      chk({secondary_idle_mode_o, secondary_run_mode_o, secondary_osc_running_o}, 3'h3);
      rdc(TCC_IDX_STAT, 32'h3);
      for (n = 0; n < 2; n++)
      begin
         wr(TCC_IDX_OSC, n[0] ? 8'h01 : 8'h81);
         sleep_req_i <= 1'b1;
         @(posedge core_clk_i);
         sleep_req_i <= 1'b0;
         @(posedge core_clk_i);
         chk({secondary_idle_mode_o, secondary_run_mode_o, secondary_osc_running_o},
            n[0] ? 3'h5 : 3'h3);
      end
      wake_i <= 1'b1;
      @(posedge core_clk_i);
      wake_i <= 1'b0;
      @(posedge core_clk_i);
      chk({secondary_idle_mode_o, secondary_run_mode_o, secondary_osc_running_o}, 3'h3);
      fscm_enable_i <= 1'b1;
      osc_fail_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      chk({secondary_idle_mode_o, secondary_run_mode_o, secondary_osc_running_o}, 3'h0);
      rdc(TCC_IDX_STAT, 32'h8);
      rdc(TCC_IDX_IRQ_ST, 32'h2);
      osc_fail_i <= 1'b0;
      summarize();
   end
endmodule // tcc_timer_ctrl_tb_top
